/* rfsch_pkg.sv */
package rfsch_pkg;

  // ----------------------------------------------------------------
  // command encoding on the command/address pins
  // ----------------------------------------------------------------
  localparam logic [3:0] RFSCH_CA_REF_MASK = 4'h7;
  localparam logic [3:0] RFSCH_CA_REF_CODE = 4'h4;
  localparam int RFSCH_CA_BIT3 = 3;
  localparam logic [3:0] RFSCH_CA_NOP = 4'h7;
  localparam logic [3:0] RFSCH_CA_ACT = 4'h0;

  // ----------------------------------------------------------------
  // timing, in ns, and cycle counts at 5 ns
  // ----------------------------------------------------------------
  localparam int RFSCH_CLK_PS = 5000;
  localparam int RFSCH_RFCAB_NS = 130;
  localparam int RFSCH_RFCPB_NS = 60;
  localparam int RFSCH_RRD_NS = 10;
  localparam logic [15:0] RFSCH_RFCAB_CYC = 16'((RFSCH_RFCAB_NS * 1000 + RFSCH_CLK_PS - 1) / RFSCH_CLK_PS);
  localparam logic [15:0] RFSCH_RFCPB_CYC = 16'((RFSCH_RFCPB_NS * 1000 + RFSCH_CLK_PS - 1) / RFSCH_CLK_PS);
  localparam logic [15:0] RFSCH_RRD_CYC = 16'((RFSCH_RRD_NS * 1000 + RFSCH_CLK_PS - 1) / RFSCH_CLK_PS);
  localparam int RFSCH_REFI_NS = 7800;
  localparam int RFSCH_REFI_CYC = (RFSCH_REFI_NS * 1000) / RFSCH_CLK_PS;
  localparam int RFSCH_REFW_MS = 32;
  localparam int RFSCH_BURST_MAX = 8;
  localparam int RFSCH_BURST_MULT = 4;
  localparam logic [15:0] RFSCH_REFBW_CYC = 16'(RFSCH_BURST_MULT * RFSCH_BURST_MAX) * RFSCH_RFCAB_CYC;
  localparam int RFSCH_REQ_COUNT = 4096;
  localparam logic [2:0] RFSCH_RATE_NOMINAL = 3'h3;
  localparam int RFSCH_NBANK = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic [3:0] ca;
    logic [2:0] bank;
  } rfsch_cmd_type;

  typedef struct packed {
    logic [15:0] rfcab;
    logic [15:0] rfcpb;
    logic [15:0] rrd;
  } rfsch_tim_type;

  // ---- rate multiplier, in quarters, from the refresh rate field
  function automatic logic [3:0] rfsch_rate_quarters(input logic [2:0] rate);
    case (rate)
      3'h1: rfsch_rate_quarters = 4'hF;
      3'h2: rfsch_rate_quarters = 4'h8;
      3'h3: rfsch_rate_quarters = 4'h4;
      3'h4: rfsch_rate_quarters = 4'h2;
      3'h5: rfsch_rate_quarters = 4'h1;
      default: rfsch_rate_quarters = 4'h4;
    endcase
  endfunction

endpackage

/* rfsch_down_timer.sv */
`timescale 1ns/1ps
module rfsch_down_timer
  import rfsch_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [15:0] value,
  // status
  output logic busy
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // --------------------------------------------------------------
  // count down from a load, busy while nonzero
  // --------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = (value != 16'h0000) ? value - 16'h0001 : 16'h0000; // load cycle counts as one
    else if (cnt_q != 16'h0000)
      cnt_d = cnt_q - 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  assign busy = (cnt_q != 16'h0000);

endmodule

/* rfsch_burst_window.sv */
`timescale 1ns/1ps
module rfsch_burst_window
  import rfsch_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events
  input wire logic all_ref,
  input wire logic [15:0] window_cyc,
  // status
  output logic full
);

  // age of each of the last eight all-bank refreshes
  logic [15:0] age_q [RFSCH_BURST_MAX];
  logic [15:0] age_d [RFSCH_BURST_MAX];
  logic [3:0] live;

  // --------------------------------------------------------------
  // shift in a fresh age per refresh, age the rest
  // --------------------------------------------------------------
  always_comb
  begin
    live = 4'h0;
    for (int i = 0; i < RFSCH_BURST_MAX; i++)
    begin
      age_d[i] = (age_q[i] != 16'h0000) ? age_q[i] - 16'h0001 : 16'h0000;
      if (age_q[i] != 16'h0000)
        live = live + 4'h1;
    end
    if (all_ref)
    begin
      for (int i = RFSCH_BURST_MAX - 1; i > 0; i--)
        age_d[i] = (age_q[i - 1] != 16'h0000) ? age_q[i - 1] - 16'h0001 : 16'h0000;
      age_d[0] = window_cyc - 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < RFSCH_BURST_MAX; i++)
    begin
      if (!rst_n)
        age_q[i] <= 16'h0000;
      else
        age_q[i] <= age_d[i];
    end
  end

  assign full = (live == 4'(RFSCH_BURST_MAX));

endmodule

/* rfsch_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - refresh code: cs low, ca0 ca1 low, ca2 high; ca3 high all-bank
// - bank counter 0..7 round robin, cleared by reset, self-refresh exit, all-bank refresh
// - after all-bank refresh, wait its cycle time before refresh or activate
// - after one-bank refresh, wait its cycle time before refresh or same-bank activate
// - after one-bank refresh, other-bank activate waits row-to-row delay
// - after activate, one-bank refresh to another idle bank waits row-to-row delay
// - two activates to different banks separated by row-to-row delay
// - refresh only idle banks; all-bank needs every bank idle
// - enough all-bank refreshes within each rolling refresh window
// - window and interval scaled by refresh rate field multiplier
// - at most eight all-bank refreshes per rolling burst window
// - burst limit applies only to all-bank refresh
// - self-refresh time lowers the required count, rounded up; the code does not track it, exit reloads the full count in burst mode
// - regular scheme issues one refresh per average interval
// - burst scheme may issue at maximum rate then pause
// - switch to regular scheme only directly after a burst phase
// - enter self refresh only after burst; restart with burst on exit; in burst mode sr_ok is also high in the idle phase
// - other banks stay usable during a one-bank refresh
module rfsch_ctrl
  import rfsch_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic [2:0] rate_field,
  input wire logic burst_mode,
  input wire logic use_one_bank,
  input wire rfsch_tim_type tim,
  // user activate request
  input wire logic act_req,
  input wire logic [2:0] act_bank,
  output logic act_ready,
  // bank state from the user side
  input wire logic [7:0] bank_open,
  input wire logic sr_exit,
  output logic sr_ok,
  // refresh request status
  output logic ref_pending,
  // command pins
  output rfsch_cmd_type cmd_q,
  output logic [2:0] next_ref_bank
);

  typedef enum logic [1:0] {
    RFSCH_IDLE = 2'b00,
    RFSCH_BURST = 2'b01,
    RFSCH_PAUSE = 2'b10
  } rfsch_phase_type;

  rfsch_phase_type phase_q;
  rfsch_phase_type phase_d;
  rfsch_cmd_type cmd_d;
  logic [2:0] bank_q;
  logic [2:0] bank_d;
  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic [15:0] owed_q;
  logic [15:0] owed_d;
  logic post_burst_q;
  logic post_burst_d;
  logic [2:0] pb_bank_q;
  logic [2:0] pb_bank_d;
  logic [31:0] interval;
  logic ab_busy;
  logic pb_busy;
  logic rrd_pb_busy;
  logic act_busy;
  logic win_full;
  logic do_ab;
  logic do_pb;
  logic do_act;
  logic pb_ok;
  logic ab_ok;
  logic [3:0] mult;

  // --------------------------------------------------------------
  // separation timers
  // --------------------------------------------------------------
  rfsch_down_timer u_ab (
    .clk(clk),
    .rst_n(rst_n),
    .load(do_ab),
    .value(tim.rfcab),
    .busy(ab_busy)
  );

  rfsch_down_timer u_pb (
    .clk(clk),
    .rst_n(rst_n),
    .load(do_pb),
    .value(tim.rfcpb),
    .busy(pb_busy)
  );

  rfsch_down_timer u_pbrrd (
    .clk(clk),
    .rst_n(rst_n),
    .load(do_pb),
    .value(tim.rrd),
    .busy(rrd_pb_busy)
  );

  rfsch_down_timer u_act (
    .clk(clk),
    .rst_n(rst_n),
    .load(do_act),
    .value(tim.rrd),
    .busy(act_busy)
  );

  rfsch_burst_window u_win (
    .clk(clk),
    .rst_n(rst_n),
    .all_ref(do_ab),
    .window_cyc(16'(RFSCH_BURST_MULT * RFSCH_BURST_MAX) * tim.rfcab),
    .full(win_full)
  );

  // --------------------------------------------------------------
  // refresh interval from rate field
  // --------------------------------------------------------------
  always_comb
  begin
    mult = rfsch_rate_quarters(rate_field);
    interval = 32'((RFSCH_REFI_CYC / 4) * int'(mult));
  end

  // --------------------------------------------------------------
  // issue decision
  // --------------------------------------------------------------
  always_comb
  begin
    ab_ok = !ab_busy && !pb_busy && (bank_open == 8'h00) && !win_full;
    pb_ok = !ab_busy && !pb_busy && !bank_open[bank_q] && !act_busy;
    do_ab = 1'b0;
    do_pb = 1'b0;
    do_act = 1'b0;
    if (owed_q != 16'h0000)
    begin
      if (use_one_bank)
        do_pb = pb_ok;
      else
        do_ab = ab_ok;
    end
    act_ready = !ab_busy && !act_busy && !do_ab && !do_pb
                && !(pb_busy && act_bank == pb_bank_q) && !rrd_pb_busy;
    do_act = act_req && act_ready;
  end

  // --------------------------------------------------------------
  // scheduler state: owed refreshes, bank counter, phase
  // --------------------------------------------------------------
  always_comb
  begin
    phase_d = phase_q;
    tick_d = tick_q + 32'h1;
    owed_d = owed_q;
    post_burst_d = 1'b0;
    bank_d = bank_q;
    pb_bank_d = pb_bank_q;
    cmd_d.cs_n = 1'b1;
    cmd_d.ca = RFSCH_CA_NOP;
    cmd_d.bank = 3'h0;
    if (do_ab || do_pb)
      owed_d = owed_q - 16'h1;
    case (phase_q)
      RFSCH_IDLE:
      begin
        if (tick_q >= interval - 32'h1)
        begin
          tick_d = 32'h0;
          owed_d = owed_d + 16'h1;
        end
        if (burst_mode && owed_d == 16'h0000)
        begin
          phase_d = RFSCH_BURST;
          owed_d = 16'(RFSCH_REQ_COUNT);
          tick_d = 32'h0;
        end
      end
      RFSCH_BURST:
      begin
        // drain a whole window's count at max rate
        if (owed_d == 16'h0000)
        begin
          phase_d = burst_mode ? RFSCH_PAUSE : RFSCH_IDLE;
          post_burst_d = burst_mode;
        end
      end
      RFSCH_PAUSE:
      begin
        if (tick_q >= interval * 32'(RFSCH_REQ_COUNT) - 32'h1)
        begin
          phase_d = RFSCH_BURST;
          owed_d = 16'(RFSCH_REQ_COUNT);
          tick_d = 32'h0;
        end
      end
      default:
        phase_d = RFSCH_IDLE;
    endcase
    if (do_ab)
    begin
      cmd_d.cs_n = 1'b0;
      cmd_d.ca = RFSCH_CA_REF_CODE | 4'h8;
      bank_d = 3'h0;
    end
    else if (do_pb)
    begin
      cmd_d.cs_n = 1'b0;
      cmd_d.ca = RFSCH_CA_REF_CODE;
      cmd_d.bank = bank_q;
      pb_bank_d = bank_q;
      bank_d = bank_q + 3'h1;
    end
    else if (do_act)
    begin
      cmd_d.cs_n = 1'b0;
      cmd_d.ca = RFSCH_CA_ACT;
      cmd_d.bank = act_bank;
    end
    if (sr_exit)
    begin
      bank_d = 3'h0;
      // internal refresh covered the gap, restart with burst
      if (burst_mode)
      begin
        post_burst_d = 1'b0;
        phase_d = RFSCH_BURST;
        owed_d = 16'(RFSCH_REQ_COUNT);
        tick_d = 32'h0;
      end
      else
        owed_d = 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_q <= RFSCH_IDLE;
      tick_q <= 32'h0;
      owed_q <= 16'h0;
      post_burst_q <= 1'b0;
      bank_q <= 3'h0;
      pb_bank_q <= 3'h0;
      cmd_q <= '{cs_n: 1'b1, ca: RFSCH_CA_NOP, bank: 3'h0};
    end
    else
    begin
      phase_q <= phase_d;
      tick_q <= tick_d;
      owed_q <= owed_d;
      post_burst_q <= post_burst_d;
      bank_q <= bank_d;
      pb_bank_q <= pb_bank_d;
      cmd_q <= cmd_d;
    end
  end

  // --------------------------------------------------------------
  // status
  // --------------------------------------------------------------
  assign ref_pending = (owed_q != 16'h0000);
  assign next_ref_bank = bank_q;
  assign sr_ok = burst_mode ? post_burst_q || (phase_q == RFSCH_IDLE)
                            : (owed_q == 16'h0000);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_ref_code;
    @(posedge clk) disable iff (!rst_n)
      (do_ab || do_pb) |=> (!cmd_q.cs_n && (cmd_q.ca & RFSCH_CA_REF_MASK) == RFSCH_CA_REF_CODE);
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("refresh code wrong");

  property p_bank_wrap;
    @(posedge clk) disable iff (!rst_n)
      (do_pb && !sr_exit) |=> (bank_q == $past(bank_q) + 3'h1);
  endproperty
  a_bank_wrap: assert property (p_bank_wrap) else $error("bank counter did not step");

  property p_ab_clear;
    @(posedge clk) disable iff (!rst_n)
      do_ab |=> (bank_q == 3'h0);
  endproperty
  a_ab_clear: assert property (p_ab_clear) else $error("bank counter not cleared");

  sequence s_ab_gap;
    !(do_ab || do_pb || do_act) [*4];
  endsequence
  property p_ab_sep;
    @(posedge clk) disable iff (!rst_n)
      (do_ab && tim.rfcab >= 16'h5) |=> s_ab_gap;
  endproperty
  a_ab_sep: assert property (p_ab_sep) else $error("command inside all-bank cycle");

  property p_pb_sep;
    @(posedge clk) disable iff (!rst_n)
      (do_pb && tim.rfcpb >= 16'h3) |=> !(do_ab || do_pb) [*2];
  endproperty
  a_pb_sep: assert property (p_pb_sep) else $error("refresh inside one-bank cycle");

  property p_act_rrd;
    @(posedge clk) disable iff (!rst_n)
      (do_act && tim.rrd >= 16'h2) |=> !do_act && !do_pb;
  endproperty
  a_act_rrd: assert property (p_act_rrd) else $error("row-to-row delay broken");

  property p_pb_act;
    @(posedge clk) disable iff (!rst_n)
      (do_pb && tim.rrd >= 16'h2) |=> !do_act;
  endproperty
  a_pb_act: assert property (p_pb_act) else $error("activate too soon after refresh");

  property p_idle;
    @(posedge clk) disable iff (!rst_n)
      (do_ab |-> bank_open == 8'h00) and (do_pb |-> !bank_open[bank_q]);
  endproperty
  a_idle: assert property (p_idle) else $error("refresh of open bank");

  property p_burst;
    @(posedge clk) disable iff (!rst_n)
      win_full |-> !do_ab;
  endproperty
  a_burst: assert property (p_burst) else $error("burst limit exceeded");

endmodule

/* rfsch_mem_model.sv */
`timescale 1ns/1ps
module rfsch_mem_model
  import rfsch_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command side
  input wire rfsch_cmd_type cmd,
  input wire logic sr_exit,
  input wire logic [7:0] bank_open,
  input wire rfsch_tim_type tim,
  // model status
  output logic [2:0] bank_cnt,
  output int viol
);
  int t = 0;
  int t_ab;
  int t_pb;
  int t_act;
  logic [2:0] pb_bank;
  int hist[$];
  // decode each command at the edge, keep the bank counter, count illegal spacing
  always @(posedge clk)
  begin
    t = t + 1;
    if (!rst_n)
    begin
      bank_cnt = 3'h0;
      pb_bank = 3'h0;
      t_ab = -1000;
      t_pb = -1000;
      t_act = -1000;
      viol = 0;
      hist.delete();
    end
    else if (!cmd.cs_n && ((cmd.ca & RFSCH_CA_REF_MASK) == RFSCH_CA_REF_CODE))
    begin
      if (t - t_ab < tim.rfcab) viol++;
      if (t - t_pb < tim.rfcpb) viol++;
      if (cmd.ca[RFSCH_CA_BIT3])
      begin
        if (bank_open != 8'h00) viol++;
        hist.push_back(t);
        while (t - hist[0] >= 32 * tim.rfcab) void'(hist.pop_front());
        if (hist.size() > 8) viol++;
        t_ab = t;
        bank_cnt = 3'h0;
      end
      else
      begin
        if (bank_open[bank_cnt]) viol++;
        if (t - t_act < tim.rrd) viol++;
        t_pb = t;
        pb_bank = bank_cnt;
        bank_cnt = bank_cnt + 3'h1;
      end
    end
    else if (!cmd.cs_n && cmd.ca == RFSCH_CA_ACT)
    begin
      if (t - t_ab < tim.rfcab) viol++;
      if (cmd.bank == pb_bank && t - t_pb < tim.rfcpb) viol++;
      if (cmd.bank != pb_bank && t - t_pb < tim.rrd) viol++;
      if (t - t_act < tim.rrd) viol++;
      t_act = t;
    end
    if (rst_n && sr_exit) bank_cnt = 3'h0;
  end
endmodule

/* refresh_scheduling_rules_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s: expected %0h seen %0h", nm, (exp), (got)); end end
module refresh_scheduling_rules_bench
  import rfsch_pkg::*;
();
  logic clk;
  logic rst_n;
  logic [2:0] rate_field;
  logic burst_mode;
  logic use_one_bank;
  rfsch_tim_type tim;
  logic act_req;
  logic [2:0] act_bank;
  logic act_ready;
  logic [7:0] bank_open;
  logic sr_exit;
  logic sr_ok;
  logic ref_pending;
  rfsch_cmd_type cmd_q;
  logic [2:0] next_ref_bank;
  logic [2:0] mdl_bank;
  logic one_q = 1'b1;
  bit exp_clr = 1'b0;
  int viol;
  int fail_count = 0;
  int checked = 0;
  int nref = 0;
  int exp_bank = 0;
  logic [2:0] act_seen = 3'h0;
  int cyc = 0;
  int last_ref = 0;
  int ref_gap = 0;

  rfsch_ctrl dut_u (.clk(clk), .rst_n(rst_n), .rate_field(rate_field), .burst_mode(burst_mode),
    .use_one_bank(use_one_bank), .tim(tim), .act_req(act_req), .act_bank(act_bank),
    .act_ready(act_ready), .bank_open(bank_open), .sr_exit(sr_exit), .sr_ok(sr_ok),
    .ref_pending(ref_pending), .cmd_q(cmd_q), .next_ref_bank(next_ref_bank));
  rfsch_mem_model mem_u (.clk(clk), .rst_n(rst_n), .cmd(cmd_q), .sr_exit(sr_exit),
    .bank_open(bank_open), .tim(tim), .bank_cnt(mdl_bank), .viol(viol));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // note self-refresh exit and refresh kind at the sampling edge
  always @(posedge clk)
  begin
    if (sr_exit) exp_clr = 1'b1;
    one_q <= use_one_bank;
    act_seen <= act_bank;
    cyc <= cyc + 1;
  end

  // reference bank counter, stepped by each one-bank refresh seen, cleared by all-bank
  always @(negedge clk)
  begin
    if (rst_n && !cmd_q.cs_n)
    begin
      if ((cmd_q.ca & RFSCH_CA_REF_MASK) == RFSCH_CA_REF_CODE)
      begin
        nref++;
        ref_gap = cyc - last_ref;
        last_ref = cyc;
        `CHK("ref_kind", cmd_q.ca[RFSCH_CA_BIT3], ~one_q)
        if (!cmd_q.ca[RFSCH_CA_BIT3])
        begin
          `CHK("ref_bank", cmd_q.bank, 3'(exp_bank))
          exp_bank = (exp_bank + 1) % 8;
        end
        else
          exp_bank = 0;
      end
      else
      begin
        `CHK("act_code", cmd_q.ca, RFSCH_CA_ACT)
        `CHK("act_bank", cmd_q.bank, act_seen)
      end
    end
    if (exp_clr) exp_bank = 0;
    exp_clr = 1'b0;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // wait for the next refresh under a bound
  task automatic wait_ref(input int lim);
    int n0;
    int i;
    n0 = nref;
    for (i = 0; i < lim && nref == n0; i++)
      @(posedge clk);
    @(negedge clk);
    `CHK("ref_seen", nref != n0, 1'b1)
    if (nref == n0) test_done();
  endtask

  // hold an activate request until taken; leaves act_req high
  task automatic do_act(input logic [2:0] b);
    int i;
    act_req = 1'b1;
    act_bank = b;
    for (i = 0; i < 100; i++)
    begin
      #1;
      if (act_ready === 1'b1) break;
      @(negedge clk);
    end
    @(negedge clk);
    `CHK("act_taken", i < 100, 1'b1)
    if (i >= 100) test_done();
  endtask

  task automatic pulse_sr();
    sr_exit = 1'b1;
    tick(1);
    sr_exit = 1'b0;
  endtask

  initial
  begin
    int k;
    int n0;
    logic [2:0] b;
    void'($urandom(32'h9C34));
    rst_n = 1'b0;
    rate_field = 3'h5;
    burst_mode = 1'b0;
    use_one_bank = 1'b1;
    tim = {RFSCH_RFCAB_CYC, RFSCH_RFCPB_CYC, RFSCH_RRD_CYC};
    act_req = 1'b0;
    act_bank = 3'h0;
    bank_open = 8'h00;
    sr_exit = 1'b0;
    tick(8);
    rst_n = 1'b1;
    tick(1);
    `CHK("idle_cs", cmd_q.cs_n, 1'b1)
    `CHK("reset_bank", next_ref_bank, 3'h0)
    // one-bank refreshes through a counter wrap, activates around one of them
    for (k = 0; k < 10; k++)
    begin
      wait_ref(500);
      `CHK("bank_cnt", next_ref_bank, 3'(exp_bank))
      `CHK("mdl_bank", next_ref_bank, mdl_bank)
      `CHK("sr_ok", sr_ok, 1'b1)
      if (k > 0)
        `CHK("ref_gap", ref_gap, RFSCH_REFI_CYC / 4)
      if (k == 3)
      begin
        do_act(3'(exp_bank));
        do_act(3'((exp_bank + 7) % 8));
        act_req = 1'b0;
      end
    end
    // target bank open: refresh held back
    n0 = nref;
    bank_open = 8'h01 << exp_bank;
    tick(450);
    `CHK("blocked", nref, n0)
    `CHK("pending", ref_pending, 1'b1)
    bank_open = 8'h00;
    wait_ref(100);
    // self-refresh exit restarts the counter
    pulse_sr();
    tick(1);
    `CHK("sr_bank", next_ref_bank, 3'h0)
    wait_ref(100);
    // all-bank refresh, then back-to-back random activates
    use_one_bank = 1'b0;
    wait_ref(500);
    `CHK("ab_bank", next_ref_bank, 3'h0)
    b = 3'($urandom % 8);
    for (k = 0; k < 6; k++)
    begin
      b = 3'((b + 1 + $urandom % 7) % 8);
      do_act(b);
    end
    act_req = 1'b0;
    // burst scheme: all-bank at the limited rate
    burst_mode = 1'b1;
    pulse_sr();
    n0 = nref;
    tick(32 * RFSCH_RFCAB_CYC + 8);
    `CHK("burst_min", nref - n0 >= 8, 1'b1)
    `CHK("burst_owed", ref_pending, 1'b1)
    `CHK("sr_burst", sr_ok, 1'b0)
    // one-bank refreshes are not rate limited
    use_one_bank = 1'b1;
    n0 = nref;
    tick(32 * RFSCH_RFCAB_CYC);
    `CHK("pb_burst", nref - n0 > 8, 1'b1)
    `CHK("spacing", viol, 0)
    test_done();
  end
endmodule
